// ===== design/aboe_pkg.sv
// Shared types and constants for the accumulator and bit-operation execution block
package aboe_pkg;

	// ==========================================================
	// Widths and constants
	localparam int ABOE_DW = 8;
	localparam int ABOE_AW = 7;
	localparam int ABOE_BW = 3;
	localparam int ABOE_NW = 4;
	localparam logic DEST_ACC = 1'h0;
	localparam logic DEST_FILE = 1'h1;
	localparam logic [ABOE_DW-1:0] ACC_RST = 8'h00;
	localparam logic [ABOE_DW-1:0] ZERO_BYTE = 8'h00;
	localparam logic [ABOE_DW-1:0] ONE_HOT_LSB = 8'h01;
	localparam logic [ABOE_AW-1:0] ADDR_RST = 7'h00;
	localparam logic FLAG_RST = 1'h0;

	// ==========================================================
	// Operations executed by this block
	typedef enum logic [2:0] {
		OP_ADD_LIT = 3'h0,
		OP_ADD_FILE = 3'h1,
		OP_AND_LIT = 3'h2,
		OP_AND_FILE = 3'h3,
		OP_CLR_BIT = 3'h4,
		OP_SET_BIT = 3'h5,
		OP_SKIP_LOW = 3'h6,
		OP_SKIP_HIGH = 3'h7
	} aboe_op_e;

	// Slot state: normal execution or the substituted idle slot
	typedef enum logic {
		ST_RUN = 1'h0,
		ST_IDLE = 1'h1
	} aboe_state_e;

	// Decoded instruction from the core
	typedef struct packed {
		logic valid;
		aboe_op_e op;
		logic [ABOE_DW-1:0] lit;
		logic [ABOE_AW-1:0] addr;
		logic dest;
		logic [ABOE_BW-1:0] bit_idx;
	} aboe_req_s;

	// Write-back toward the register file
	typedef struct packed {
		logic en;
		logic [ABOE_AW-1:0] addr;
		logic [ABOE_DW-1:0] data;
	} aboe_fwr_s;

endpackage : aboe_pkg

// ===== design/aboe_nib_add.sv
// Four-bit adder slice with carry in and carry out
`timescale 1ns/1ps
`default_nettype none
module aboe_nib_add
	import aboe_pkg::*;
(
	input wire logic [ABOE_NW-1:0] a, // First addend
	input wire logic [ABOE_NW-1:0] b, // Second addend
	input wire logic ci, // Carry in
	output logic [ABOE_NW-1:0] s, // Sum
	output logic co // Carry out of the top bit
);
	// ==========================================================
	// Sum with one extra bit to catch the carry
	assign {co, s} = {1'h0, a} + {1'h0, b} + {4'h0, ci};
endmodule : aboe_nib_add
`default_nettype wire

// ===== design/aboe_exec.sv
// Execution datapath for add, AND, bit clear/set and bit-test skip instructions
`timescale 1ns/1ps
`default_nettype none
module aboe_exec
	import aboe_pkg::*;
(
	input wire logic clk, // Core clock, 100 MHz
	input wire logic sys_rst, // Synchronous reset, active high
	input wire aboe_req_s req, // Decoded instruction, one per cycle
	input wire logic [ABOE_DW-1:0] file_rd_data, // Register file read of req.addr
	input wire logic port_sel, // req.addr is an I/O port register
	input wire logic [ABOE_DW-1:0] port_pins, // Asynchronous pin levels of that port
	input wire logic timer_zero_sel, // req.addr is timer_zero_count
	input wire logic prescaler_to_timer, // Prescaler assigned to timer zero
	output logic [ABOE_DW-1:0] acc, // Accumulator
	output logic carry_flag, // Carry
	output logic half_carry_flag, // Half carry
	output logic zero_flag, // Zero
	output aboe_fwr_s file_wr, // Register file write, one-cycle pulse
	output logic prescaler_clr, // Prescaler clear, one-cycle pulse
	output logic idle_slot, // Discarded instruction slot, one-cycle pulse
	output logic retire // Instruction executed, one-cycle pulse
);
	// ==========================================================
	// State
	aboe_state_e state_r, state_nxt;
	logic [ABOE_DW-1:0] acc_r, acc_nxt;
	logic carry_r, carry_nxt, hc_r, hc_nxt, zero_r, zero_nxt;
	aboe_fwr_s fwr_r, fwr_nxt;
	logic psc_r, idle_r, retire_r;
	logic [ABOE_DW-1:0] pin_meta_r, pin_sync_r;

	// ==========================================================
	// Pin synchroniser; the first stage feeds only the second
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			pin_meta_r <= ZERO_BYTE;
			pin_sync_r <= ZERO_BYTE;
		end else begin
			pin_meta_r <= port_pins;
			pin_sync_r <= pin_meta_r;
		end
	end

	// ==========================================================
	// Decode; a request during the idle slot is dropped here
	wire issue = req.valid && (state_r == ST_RUN);
	wire op_add_lit = req.op == OP_ADD_LIT;
	wire op_add_file = req.op == OP_ADD_FILE;
	wire op_and_lit = req.op == OP_AND_LIT;
	wire op_and_file = req.op == OP_AND_FILE;
	wire op_clr = req.op == OP_CLR_BIT;
	wire op_set = req.op == OP_SET_BIT;
	wire op_add = op_add_lit || op_add_file;
	wire op_and = op_and_lit || op_and_file;
	wire op_lit = op_add_lit || op_and_lit;
	wire op_file_alu = op_add_file || op_and_file;

	// pins as operand
	// Operand from the pins, so an input held low outside reads low here
	wire [ABOE_DW-1:0] file_opnd = port_sel ? pin_sync_r : file_rd_data;
	wire [ABOE_DW-1:0] src = op_lit ? req.lit : file_opnd;

	// carry from bits 3 and 7
	// Split adder exposes the nibble carry without a second adder
	wire [ABOE_NW-1:0] sum_lo, sum_hi;
	wire c3, c7;
	aboe_nib_add u_add_lo (
		.a(acc_r[ABOE_NW-1:0]),
		.b(src[ABOE_NW-1:0]),
		.ci(1'h0),
		.s(sum_lo),
		.co(c3)
	);
	aboe_nib_add u_add_hi (
		.a(acc_r[ABOE_DW-1:ABOE_NW]),
		.b(src[ABOE_DW-1:ABOE_NW]),
		.ci(c3),
		.s(sum_hi),
		.co(c7)
	);

	// Bit mask and result selection
	wire [ABOE_DW-1:0] bit_mask = ONE_HOT_LSB << req.bit_idx;
	wire [ABOE_DW-1:0] alu_res = op_add ? {sum_hi, sum_lo} : (acc_r & src);
	wire [ABOE_DW-1:0] bit_res = op_set ? (file_opnd | bit_mask) : (file_opnd & ~bit_mask);

	wire to_acc = op_lit || (op_file_alu && req.dest == DEST_ACC);
	wire to_file = (op_file_alu && req.dest == DEST_FILE) || op_clr || op_set;

	wire tested = file_opnd[req.bit_idx];
	wire skip_take = (req.op == OP_SKIP_LOW && !tested) || (req.op == OP_SKIP_HIGH && tested);

	// ==========================================================
	// Next-state logic
	always_comb begin
		state_nxt = ST_RUN;
		acc_nxt = acc_r;
		carry_nxt = carry_r;
		hc_nxt = hc_r;
		zero_nxt = zero_r;
		fwr_nxt = '{en: 1'h0, addr: req.addr, data: alu_res};
		case (state_r)
			ST_RUN: begin
				if (req.valid) begin
					if (to_acc) begin
						acc_nxt = alu_res;
					end
					fwr_nxt.en = to_file;
					fwr_nxt.data = (op_clr || op_set) ? bit_res : alu_res;
					if (op_add || op_and) begin
						zero_nxt = (alu_res == ZERO_BYTE);
					end
					if (op_add) begin
						carry_nxt = c7;
						hc_nxt = c3;
					end
					// taken skip adds one idle slot
					if (skip_take) begin
						state_nxt = ST_IDLE;
					end
				end
			end
			ST_IDLE: begin
				state_nxt = ST_RUN;
			end
			default: begin
				state_nxt = ST_RUN;
			end
		endcase
	end

	// ==========================================================
	// Registers; all outputs come from here
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			state_r <= ST_RUN;
			acc_r <= ACC_RST;
			carry_r <= FLAG_RST;
			hc_r <= FLAG_RST;
			zero_r <= FLAG_RST;
			fwr_r <= '{en: FLAG_RST, addr: ADDR_RST, data: ZERO_BYTE};
			psc_r <= FLAG_RST;
			idle_r <= FLAG_RST;
			retire_r <= FLAG_RST;
		end else begin
			state_r <= state_nxt;
			acc_r <= acc_nxt;
			carry_r <= carry_nxt;
			hc_r <= hc_nxt;
			zero_r <= zero_nxt;
			fwr_r <= fwr_nxt;
			psc_r <= issue && to_file && timer_zero_sel && prescaler_to_timer;
			idle_r <= issue && skip_take;
			retire_r <= issue;
		end
	end

	assign acc = acc_r;
	assign carry_flag = carry_r;
	assign half_carry_flag = hc_r;
	assign zero_flag = zero_r;
	assign file_wr = fwr_r;
	assign prescaler_clr = psc_r;
	assign idle_slot = idle_r;
	assign retire = retire_r;

	// ==========================================================
	// Assertions
	property p_add_lit;
		@(posedge clk) disable iff (sys_rst)
		(issue && op_add_lit) |=> acc_r == 8'($past(acc_r) + $past(req.lit));
	endproperty
	a_add_lit: assert property (p_add_lit) else $error("add literal result wrong");

	property p_add_file;
		@(posedge clk) disable iff (sys_rst)
		(issue && op_add_file && req.dest == DEST_FILE && !port_sel)
		|=> fwr_r.en && fwr_r.data == 8'($past(acc_r) + $past(file_rd_data));
	endproperty
	a_add_file: assert property (p_add_file) else $error("add file write-back wrong");

	property p_and_lit;
		@(posedge clk) disable iff (sys_rst)
		(issue && op_and_lit) |=> acc_r == ($past(acc_r) & $past(req.lit))
			&& $stable(carry_r) && $stable(hc_r);
	endproperty
	a_and_lit: assert property (p_and_lit) else $error("and literal wrong or flags moved");

	property p_and_file_acc;
		@(posedge clk) disable iff (sys_rst)
		(issue && op_and_file && req.dest == DEST_ACC && !port_sel)
		|=> !fwr_r.en && acc_r == ($past(acc_r) & $past(file_rd_data));
	endproperty
	a_and_file_acc: assert property (p_and_file_acc) else $error("and to accumulator wrong");

	property p_bit_ops;
		@(posedge clk) disable iff (sys_rst)
		(issue && (op_clr || op_set)) |=> fwr_r.en && $stable(acc_r) && $stable(zero_r)
			&& fwr_r.data[$past(req.bit_idx)] == $past(op_set);
	endproperty
	a_bit_ops: assert property (p_bit_ops) else $error("bit clear or set wrong");

	property p_skip;
		@(posedge clk) disable iff (sys_rst)
		(issue && skip_take) |=> idle_slot && retire ##1 !idle_slot && !retire;
	endproperty
	a_skip: assert property (p_skip) else $error("taken skip idle slot wrong");

	property p_no_skip;
		@(posedge clk) disable iff (sys_rst)
		(issue && (req.op == OP_SKIP_HIGH) && !tested) |=> !idle_slot && state_r == ST_RUN;
	endproperty
	a_no_skip: assert property (p_no_skip) else $error("untaken skip stalled");

	property p_prescaler;
		@(posedge clk) disable iff (sys_rst)
		(issue && to_file && timer_zero_sel && prescaler_to_timer) |=> prescaler_clr;
	endproperty
	a_prescaler: assert property (p_prescaler) else $error("prescaler not cleared");

	property p_zero;
		@(posedge clk) disable iff (sys_rst)
		(issue && (op_add || op_and)) |=> zero_r == ($past(alu_res) == ZERO_BYTE);
	endproperty
	a_zero: assert property (p_zero) else $error("zero flag wrong");

	property p_single;
		@(posedge clk) disable iff (sys_rst)
		(issue && !skip_take) |=> retire && state_r == ST_RUN;
	endproperty
	a_single: assert property (p_single) else $error("instruction not single cycle");
endmodule : aboe_exec
`default_nettype wire

// ===== bench/tb_top.sv
// Self-checking testbench for the accumulator and bit-operation execution block
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin \
	check_count++; \
	if ((got) !== (exp)) begin \
		miscompares++; \
		$display("MISMATCH t=%0t got=%0h exp=%0h", $time, (got), (exp)); \
	end \
end
module tb_top
	import aboe_pkg::*;
;
	logic clk;
	logic sys_rst;
	aboe_req_s req;
	logic [7:0] file_rd_data, port_pins;
	logic port_sel, timer_zero_sel, prescaler_to_timer;
	logic [7:0] acc;
	logic carry_flag, half_carry_flag, zero_flag, prescaler_clr, idle_slot, retire;
	aboe_fwr_s file_wr;
	int miscompares = 0;
	int check_count = 0;
	// Bench copy of the state the block should hold
	logic [7:0] m_acc;
	logic m_c, m_h, m_z, m_skip;

	aboe_exec u_dut (.clk(clk), .sys_rst(sys_rst), .req(req), .file_rd_data(file_rd_data),
		.port_sel(port_sel), .port_pins(port_pins), .timer_zero_sel(timer_zero_sel),
		.prescaler_to_timer(prescaler_to_timer), .acc(acc), .carry_flag(carry_flag),
		.half_carry_flag(half_carry_flag), .zero_flag(zero_flag), .file_wr(file_wr),
		.prescaler_clr(prescaler_clr), .idle_slot(idle_slot), .retire(retire));

	// ==========================================================
	// Clock and shared tasks
	always #5 clk = ~clk;

	task automatic end_sim;
		if (miscompares == 0 && check_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : end_sim

	// Reset is held six cycles, then every output but file_wr.addr and file_wr.data must read back cleared
	task automatic do_reset;
		sys_rst = 1'h1;
		req = '0;
		repeat (6) @(posedge clk);
		#1 sys_rst = 1'h0;
		{m_acc, m_c, m_h, m_z, m_skip} = '0;
		`CHK({acc, carry_flag, half_carry_flag, zero_flag, file_wr.en, prescaler_clr}, 13'h0000)
		`CHK({retire, idle_slot}, 2'h0)
	endtask : do_reset

	// Let the request line go quiet; pin changes settle through the synchroniser here
	task automatic gap(input int n);
		req.valid = 1'h0;
		repeat (n) @(posedge clk);
		#1 m_skip = 1'h0;
	endtask : gap

	// Issue one instruction, predict its outcome and judge it one edge later
	task automatic step(input aboe_op_e op, input logic [7:0] lit, input logic [6:0] a,
		input logic d, input logic [2:0] b, input logic [7:0] fd);
		logic [8:0] s;
		logic [7:0] v, x, r;
		logic we, tk, slot;
		req = '{1'h1, op, lit, a, d, b};
		file_rd_data = fd;
		v = port_sel ? port_pins : fd;
		x = (op == OP_ADD_LIT || op == OP_AND_LIT) ? lit : v;
		slot = m_skip;
		{we, tk, r} = '0;
		if (!slot) begin
			case (op)
				OP_ADD_LIT, OP_ADD_FILE: begin
					s = {1'h0, m_acc} + {1'h0, x};
					m_h = ({1'h0, m_acc[3:0]} + {1'h0, x[3:0]}) > 5'h0F;
					m_c = s[8];
					r = s[7:0];
					m_z = (r == 8'h00);
				end
				OP_AND_LIT, OP_AND_FILE: begin
					r = m_acc & x;
					m_z = (r == 8'h00);
				end
				OP_CLR_BIT: {we, r} = {1'h1, v & ~(8'h01 << b)};
				OP_SET_BIT: {we, r} = {1'h1, v | (8'h01 << b)};
				OP_SKIP_LOW: tk = ~v[b];
				default: tk = v[b];
			endcase
			if (op == OP_ADD_FILE || op == OP_AND_FILE)
				we = d;
			if ((op == OP_ADD_FILE || op == OP_AND_FILE) && !d || op == OP_ADD_LIT || op == OP_AND_LIT)
				m_acc = r;
		end
		m_skip = tk;
		@(posedge clk);
		#1;
		`CHK({acc, carry_flag, half_carry_flag, zero_flag}, {m_acc, m_c, m_h, m_z})
		`CHK({retire, idle_slot}, {~slot, tk})
		`CHK({file_wr.en, prescaler_clr}, {we, we & timer_zero_sel & prescaler_to_timer})
		if (we) `CHK({file_wr.addr, file_wr.data}, {a, r})
	endtask : step

	// ==========================================================
	// Scenarios
	task automatic t_add;
		step(OP_ADD_LIT, 8'h0F, 7'h00, 1'h0, 3'h0, 8'h00);
		step(OP_ADD_LIT, 8'h01, 7'h00, 1'h0, 3'h0, 8'h00);
		step(OP_ADD_LIT, 8'hF0, 7'h00, 1'h0, 3'h0, 8'h00);
		step(OP_ADD_FILE, 8'h00, 7'h7F, 1'h1, 3'h0, 8'h88);
		step(OP_ADD_FILE, 8'h00, 7'h00, 1'h0, 3'h0, 8'hFF);
		step(OP_ADD_LIT, 8'hFF, 7'h00, 1'h0, 3'h0, 8'h00);
		gap(1);
	endtask : t_add

	// Carry must survive the AND operations untouched
	task automatic t_and;
		step(OP_AND_LIT, 8'h0F, 7'h00, 1'h0, 3'h0, 8'h00);
		step(OP_AND_LIT, 8'h00, 7'h00, 1'h0, 3'h0, 8'h00);
		step(OP_ADD_LIT, 8'hC3, 7'h00, 1'h0, 3'h0, 8'h00);
		step(OP_AND_FILE, 8'h00, 7'h55, 1'h1, 3'h0, 8'h3C);
		step(OP_AND_FILE, 8'h00, 7'h2A, 1'h0, 3'h0, 8'hF0);
		gap(1);
	endtask : t_and

	task automatic t_bits;
		for (int i = 0; i < 8; i++) begin
			step(OP_CLR_BIT, 8'h00, 7'h20, 1'h0, i[2:0], 8'hFF);
			step(OP_SET_BIT, 8'h00, 7'h40, 1'h1, i[2:0], 8'h00);
		end
		gap(1);
	endtask : t_bits

	// Requests in the discarded slot would change state if they leaked through
	task automatic t_skip;
		step(OP_SKIP_LOW, 8'h00, 7'h10, 1'h0, 3'h2, 8'hFB);
		step(OP_ADD_LIT, 8'h11, 7'h00, 1'h0, 3'h0, 8'h00);
		step(OP_SKIP_LOW, 8'h00, 7'h10, 1'h0, 3'h2, 8'h04);
		step(OP_ADD_LIT, 8'h01, 7'h00, 1'h0, 3'h0, 8'h00);
		step(OP_SKIP_HIGH, 8'h00, 7'h11, 1'h0, 3'h7, 8'h80);
		step(OP_SKIP_HIGH, 8'h00, 7'h11, 1'h0, 3'h7, 8'h7F);
		step(OP_SKIP_HIGH, 8'h00, 7'h12, 1'h0, 3'h0, 8'h01);
		step(OP_SET_BIT, 8'h00, 7'h12, 1'h0, 3'h3, 8'h00);
		step(OP_SKIP_HIGH, 8'h00, 7'h12, 1'h0, 3'h0, 8'hFE);
		gap(1);
	endtask : t_skip

	// Pins disagree with the latch value so a wrong operand source shows
	task automatic t_port;
		port_pins = 8'hA5;
		port_sel = 1'h1;
		gap(3);
		step(OP_SET_BIT, 8'h00, 7'h05, 1'h1, 3'h1, 8'h5A);
		step(OP_SKIP_LOW, 8'h00, 7'h05, 1'h0, 3'h1, 8'h5A);
		step(OP_ADD_FILE, 8'h00, 7'h05, 1'h0, 3'h0, 8'h5A);
		step(OP_AND_FILE, 8'h00, 7'h05, 1'h1, 3'h0, 8'h5A);
		port_sel = 1'h0;
		gap(1);
	endtask : t_port

	task automatic t_timer;
		timer_zero_sel = 1'h1;
		prescaler_to_timer = 1'h1;
		step(OP_ADD_FILE, 8'h00, 7'h01, 1'h1, 3'h0, 8'h10);
		step(OP_ADD_FILE, 8'h00, 7'h01, 1'h0, 3'h0, 8'h10);
		step(OP_CLR_BIT, 8'h00, 7'h01, 1'h0, 3'h4, 8'h10);
		prescaler_to_timer = 1'h0;
		step(OP_SET_BIT, 8'h00, 7'h01, 1'h0, 3'h4, 8'h00);
		timer_zero_sel = 1'h0;
		gap(1);
	endtask : t_timer

	// ==========================================================
	// Main sequence and watchdog
	initial begin
		{clk, file_rd_data, port_sel, port_pins, timer_zero_sel, prescaler_to_timer} = '0;
		do_reset();
		t_add();
		t_and();
		t_bits();
		t_skip();
		t_port();
		t_timer();
		do_reset();
		end_sim();
	end

	initial begin
		#20000;
		miscompares++;
		end_sim();
	end
endmodule : tb_top
`default_nettype wire
